// *** hdl/dew_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * data memory write guard.
 * Assumes a 32-bit APB slave, one register per aligned word.
 */
`ifndef DEW_REGS_SVH
`define DEW_REGS_SVH

`define DEW_OFF_CTRL      12'h000
`define DEW_OFF_KEY       12'h004
`define DEW_OFF_ADDR      12'h008
`define DEW_OFF_DATA      12'h00C
`define DEW_OFF_IRQ_STAT  12'h010
`define DEW_OFF_IRQ_MASK  12'h014
`define DEW_OFF_STATUS    12'h018

`define DEW_CTRL_CODE_SEL 7
`define DEW_CTRL_CFG_SEL  6
`define DEW_CTRL_FREE     4
`define DEW_CTRL_WRERR    3
`define DEW_CTRL_ARM      2
`define DEW_CTRL_COMMIT   1
`define DEW_CTRL_READ     0
`define DEW_CTRL_WMASK    8'hDF

`define DEW_KEY_FIRST     8'h55
`define DEW_KEY_SECOND    8'hAA

`define DEW_IRQ_DONE      0
`define DEW_IRQ_REFUSED   1

`define DEW_CTRL_RST      8'h00
`define DEW_MASK_RST      8'h00

`define DEW_PWRT_NS       65600
`define DEW_PWRT_CYC      ((`DEW_PWRT_NS + 7) / 8)
`define DEW_PROG_NS       4000000
`define DEW_PROG_CYC      ((`DEW_PROG_NS + 7) / 8)

`endif

// *** hdl/dew_pkg.sv ***
/*
 * Types shared by the write guard.
 * Assumes dew_regs.svh holds the numbers.
 */
package dew_pkg;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_OPEN
    } dew_key_e;

    typedef enum logic [1:0] {
        WR_IDLE,
        WR_BUSY
    } dew_wr_e;

    // External programming port request
    typedef struct packed {
        logic       req;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dew_ext_req_s;

    // Request to the storage cell array
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dew_arr_req_s;

endpackage

// *** hdl/dew_guard.sv ***
/*
 * Data memory access and write guard behind an APB slave: key sequence,
 * arm bit, power-up write block, code-protect gate for the external port,
 * read start, write timing, done flag and interrupt.
 * Assumes a byte array that answers reads combinationally on i_arr_rdata
 * and programs whatever o_arr.wr presents.
 */
//
// Contract
// R1: code protect refuses external reads and writes
// R2: core access unaffected by code protect
// R3: power-up reset clears arm bit
// R4: no write start during power-up timer
// R5: write needs arm and completed key sequence
// R6: software writes 55h, 0AAh, then commit
// R7: software clears space selects before access
// R8: bit 5 reads zero, ignores writes
// R9: software clears arm after done
// R10: refresh polls commit until cleared
// R11: refresh walks addresses until wrap
// R12: software may read back written bytes
// R13: write end clears commit, sets done flag
// R14: read start loads data, self-clears
// R15: commit needs prior arm; registers frozen
`timescale 1ns/100ps
`include "dew_regs.svh"

module dew_guard
    import dew_pkg::*;
#(
    parameter int PWRT_CYC = `DEW_PWRT_CYC,   // Power-up timer length
    parameter int PROG_CYC = `DEW_PROG_CYC    // Cell programming time
) (
    input  wire logic         i_core_clk,   // Core clock
    input  wire logic         i_sys_rst,    // Sync reset, high
    input  wire logic         psel,         // APB select
    input  wire logic         penable,      // APB enable
    input  wire logic         pwrite,       // APB direction
    input  wire logic [11:0]  paddr,        // APB byte address
    input  wire logic [31:0]  pwdata,       // APB write data
    output logic      [31:0]  prdata,       // APB read data
    output logic              pready,       // APB ready
    output logic              pslverr,      // APB error
    input  wire logic         i_code_prot,  // Code-protect config bit
    input  wire dew_ext_req_s i_ext,        // External port request
    output logic      [7:0]   o_ext_rdata,  // External read data
    output logic              o_ext_ack,    // External access done
    output logic              o_ext_refused,// External access refused
    output dew_arr_req_s      o_arr,        // Array request
    input  wire logic [7:0]   i_arr_rdata,  // Array read data
    output logic              o_irq         // Interrupt, high level
);

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  addr_q, addr_d;
    logic [7:0]  data_q, data_d;
    logic [7:0]  stat_q, stat_d;
    logic [7:0]  mask_q, mask_d;
    dew_key_e    key_q, key_d;
    dew_wr_e     wr_q, wr_d;
    logic [31:0] pwrt_q, pwrt_d;
    logic [31:0] prog_q, prog_d;
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d;
    logic [7:0]  ext_rdata_d;
    logic        ext_ack_d, ext_ref_d;
    dew_arr_req_s arr_d;
    logic        irq_d;

    logic        acc, wr_acc, rd_acc, mapped, pwrt_run, data_sel, busy;
    logic        done_ev, refuse_ev;

    assign acc      = psel && penable;
    assign wr_acc   = acc && pwrite;
    assign rd_acc   = acc && !pwrite;
    assign pwrt_run = (pwrt_q != 32'h0);
    assign busy     = (wr_q == WR_BUSY);
    // Both space selects clear means data memory is targeted
    assign data_sel = !ctrl_q[`DEW_CTRL_CODE_SEL] && !ctrl_q[`DEW_CTRL_CFG_SEL];
    assign mapped   = (paddr == `DEW_OFF_CTRL) || (paddr == `DEW_OFF_KEY) ||
                      (paddr == `DEW_OFF_ADDR) || (paddr == `DEW_OFF_DATA) ||
                      (paddr == `DEW_OFF_IRQ_STAT) || (paddr == `DEW_OFF_IRQ_MASK) ||
                      (paddr == `DEW_OFF_STATUS);

    // ************************************************************
    // Register, key and write sequencing
    // ************************************************************
    always_comb begin
        logic [7:0] wv;
        logic       commit_req;
        wv         = pwdata[7:0];
        commit_req = 1'b0;
        ctrl_d     = ctrl_q;
        addr_d     = addr_q;
        data_d     = data_q;
        mask_d     = mask_q;
        key_d      = key_q;
        wr_d       = wr_q;
        pwrt_d     = pwrt_run ? pwrt_q - 32'h1 : pwrt_q;
        prog_d     = prog_q;
        done_ev    = 1'b0;
        refuse_ev  = 1'b0;
        arr_d      = '0;
        // Read start from the previous cycle loads data now; drop it
        if (ctrl_q[`DEW_CTRL_READ]) begin
            data_d                   = i_arr_rdata;                 // R14
            ctrl_d[`DEW_CTRL_READ]   = 1'b0;                        // R14
        end
        arr_d.addr = addr_q;
        arr_d.rd   = ctrl_q[`DEW_CTRL_READ];
        // Before the key opens, any write other than the second key write breaks the sequence
        if (wr_acc && paddr == `DEW_OFF_KEY) begin
            case (key_q)
                KEY_IDLE:      key_d = (wv == `DEW_KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
                KEY_GOT_FIRST: key_d = (wv == `DEW_KEY_SECOND) ? KEY_OPEN : KEY_IDLE;
                default:       key_d = (wv == `DEW_KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
            endcase
        end else if (wr_acc && key_q != KEY_OPEN) begin
            key_d = KEY_IDLE;
        end
        // Control, address and data registers are frozen while a write is in progress
        if (wr_acc && !busy) begin                                  // R15
            case (paddr)
                `DEW_OFF_ADDR: addr_d = wv;
                `DEW_OFF_DATA: data_d = wv;
                `DEW_OFF_CTRL: begin
                    // Bit 5 unused; a read start beside a commit would clobber the data
                    ctrl_d = (wv & `DEW_CTRL_WMASK & 8'hFC)         // R8
                           | (ctrl_d & 8'h03);
                    ctrl_d[`DEW_CTRL_COMMIT] = 1'b0;
                    ctrl_d[`DEW_CTRL_READ]   = ctrl_d[`DEW_CTRL_READ] |
                                               (wv[`DEW_CTRL_READ] && data_sel && !wv[`DEW_CTRL_COMMIT]); // R14
                    commit_req = wv[`DEW_CTRL_COMMIT];
                    key_d      = KEY_IDLE;
                end
                default: ;
            endcase
        end
        if (wr_acc && paddr == `DEW_OFF_IRQ_MASK) begin
            mask_d = wv;
        end
        // Commit needs the old arm bit, an open key and the timer expired
        if (commit_req) begin
            if (ctrl_q[`DEW_CTRL_ARM] && key_q == KEY_OPEN && !pwrt_run) begin // R5 R4 R15
                ctrl_d[`DEW_CTRL_COMMIT] = 1'b1;
                wr_d   = WR_BUSY;
                prog_d = PROG_CYC;
            end else begin
                refuse_ev = 1'b1;                                   // R5
            end
        end
        case (wr_q)
            WR_IDLE: ;
            WR_BUSY: begin
                arr_d.wr    = 1'b1;
                arr_d.rd    = 1'b0;
                arr_d.wdata = data_q;
                prog_d      = prog_q - 32'h1;
                if (prog_q == 32'h1) begin
                    wr_d = WR_IDLE;
                    ctrl_d[`DEW_CTRL_COMMIT] = 1'b0;                // R13
                    done_ev = 1'b1;                                 // R13
                end
            end
            default: wr_d = WR_IDLE;
        endcase
    end

    // ************************************************************
    // Sticky status, read-clear; a new event beats the clear
    // ************************************************************
    always_comb begin
        stat_d = stat_q;
        if (rd_acc && paddr == `DEW_OFF_IRQ_STAT) begin
            stat_d = 8'h00;
        end
        if (done_ev) begin
            stat_d[`DEW_IRQ_DONE] = 1'b1;                           // R13
        end
        if (refuse_ev) begin
            stat_d[`DEW_IRQ_REFUSED] = 1'b1;
        end
        irq_d = |(stat_d & mask_d);
    end

    // ************************************************************
    // External port, gated by code protect; core path never is
    // ************************************************************
    always_comb begin
        ext_rdata_d = o_ext_rdata;
        ext_ack_d   = 1'b0;
        ext_ref_d   = 1'b0;
        if (i_ext.req) begin
            if (i_code_prot || busy) begin
                ext_ref_d = 1'b1;                                   // R1
            end else if (!i_ext.write) begin
                ext_ack_d   = 1'b1;
                ext_rdata_d = i_arr_rdata;
            end else begin
                ext_ack_d   = 1'b1;
            end
        end
    end

    // ************************************************************
    // APB answer: one wait-free access phase
    // ************************************************************
    always_comb begin
        prdata_d  = 32'h0;
        pready_d  = psel && !penable;
        pslverr_d = psel && !penable && !mapped;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `DEW_OFF_CTRL:     prdata_d = {24'h0, ctrl_q & `DEW_CTRL_WMASK}; // R8
                `DEW_OFF_ADDR:     prdata_d = {24'h0, addr_q};
                `DEW_OFF_DATA:     prdata_d = {24'h0, data_d};              // R2
                `DEW_OFF_IRQ_STAT: prdata_d = {24'h0, stat_d};
                `DEW_OFF_IRQ_MASK: prdata_d = {24'h0, mask_q};
                `DEW_OFF_STATUS:   prdata_d = {30'h0, pwrt_run, key_q == KEY_OPEN};
                default:           prdata_d = 32'h0;
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ctrl_q        <= `DEW_CTRL_RST;                         // R3
            addr_q        <= 8'h00;
            data_q        <= 8'h00;
            stat_q        <= 8'h00;
            mask_q        <= `DEW_MASK_RST;
            key_q         <= KEY_IDLE;
            wr_q          <= WR_IDLE;
            pwrt_q        <= PWRT_CYC;                              // R4
            prog_q        <= 32'h0;
            prdata        <= 32'h0;
            pready        <= 1'b0;
            pslverr       <= 1'b0;
            o_ext_rdata   <= 8'h00;
            o_ext_ack     <= 1'b0;
            o_ext_refused <= 1'b0;
            o_arr         <= '0;
            o_irq         <= 1'b0;
        end else begin
            ctrl_q        <= ctrl_d;
            addr_q        <= addr_d;
            data_q        <= data_d;
            stat_q        <= stat_d;
            mask_q        <= mask_d;
            key_q         <= key_d;
            wr_q          <= wr_d;
            pwrt_q        <= pwrt_d;
            prog_q        <= prog_d;
            prdata        <= prdata_d;
            pready        <= pready_d;
            pslverr       <= pslverr_d;
            o_ext_rdata   <= ext_rdata_d;
            o_ext_ack     <= ext_ack_d;
            o_ext_refused <= ext_ref_d;
            o_arr         <= arr_d;
            o_irq         <= irq_d;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    prot_refuse_a: assert property (i_ext.req && i_code_prot |=> o_ext_refused && !o_ext_ack) // R1
        else $error("external access not refused under protect");
    core_read_a: assert property (rd_acc && paddr == `DEW_OFF_DATA |-> pready && !pslverr &&
                                  prdata == {24'h0, $past(data_d)}) // R2
        else $error("core data read blocked");
    arm_reset_a: assert property ($fell(i_sys_rst) |-> !ctrl_q[`DEW_CTRL_ARM]) // R3
        else $error("arm bit set after reset");
    pwrt_block_a: assert property (pwrt_run |=> !(busy && !$past(busy))) // R4
        else $error("write started in power-up time");
    commit_cond_a: assert property (!busy ##1 busy |-> $past(ctrl_q[`DEW_CTRL_ARM]) && $past(key_q) == KEY_OPEN) // R5
        else $error("write started without arm and key");
    bit5_zero_a: assert property (pready && !$past(pwrite) && $past(paddr) == `DEW_OFF_CTRL |-> prdata[5] == 1'b0) // R8
        else $error("bit 5 not zero");
    done_flag_a: assert property (done_ev |=> !ctrl_q[`DEW_CTRL_COMMIT] && stat_q[`DEW_IRQ_DONE]) // R13
        else $error("write end not flagged");
    read_clear_a: assert property (ctrl_q[`DEW_CTRL_READ] |=> !ctrl_q[`DEW_CTRL_READ] && data_q == $past(i_arr_rdata)) // R14
        else $error("read start not completed");
    frozen_a: assert property (busy && $past(busy) |-> $stable(addr_q) && $stable(data_q)) // R15
        else $error("registers changed during write");

    write_done_c: cover property (busy ##1 !busy);
    key_open_c:   cover property (key_q == KEY_GOT_FIRST ##1 key_q == KEY_OPEN);
    refuse_c:     cover property (refuse_ev);
    irq_c:        cover property (o_irq);

endmodule

// *** tb/dew_guard_tb.sv ***
/*
 * Self-checking bench of the data memory write guard, driven over APB.
 * Assumes dew_guard with short timer parameters and a bench-driven array.
 */
`timescale 1ns/100ps
`include "dew_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end

module testbench
    import dew_pkg::*;
;
    localparam int PWRT = 40;   // Short power-up timer for simulation
    localparam int PROG = 20;   // Long enough to poke registers mid-write

    logic         i_core_clk = 1'b0;
    logic         i_sys_rst;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         i_code_prot;
    dew_ext_req_s i_ext;
    logic [7:0]   o_ext_rdata;
    logic         o_ext_ack;
    logic         o_ext_refused;
    dew_arr_req_s o_arr;
    logic [7:0]   i_arr_rdata;
    logic         o_irq;
    logic [31:0]  rd;
    logic         err;
    int           n_fail = 0;
    int           tests_run = 0;

    dew_guard #(.PWRT_CYC(PWRT), .PROG_CYC(PROG)) i_dut (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_code_prot(i_code_prot), .i_ext(i_ext), .o_ext_rdata(o_ext_rdata),
        .o_ext_ack(o_ext_ack), .o_ext_refused(o_ext_refused), .o_arr(o_arr),
        .i_arr_rdata(i_arr_rdata), .o_irq(o_irq)
    );

    // 125 MHz core clock
    initial begin
        forever #4 i_core_clk = ~i_core_clk;
    end

    // One APB transfer; the request stands until pready is seen high or 20 cycles have passed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_core_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        `CHK(pready, 1'b1)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic chk_rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        apb(1'b0, a, 32'h0);
        `CHK(rd[7:0] & m, e)
    endtask

    task automatic unlock;
        wr(`DEW_OFF_KEY, `DEW_KEY_FIRST);
        wr(`DEW_OFF_KEY, `DEW_KEY_SECOND);
    endtask

    // Polls commit bit with a bound, as refresh software does
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, `DEW_OFF_CTRL, 32'h0);
            n++;
        end while (rd[1] !== 1'b0 && n < 50);
        `CHK(rd[1], 1'b0)
    endtask

    // External port access; ack and refused are one-cycle pulses
    task automatic ext(input logic w, input logic exp_ack);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_ext <= '{1'b1, w, 8'h08, 8'h99};
        @(posedge i_core_clk);
        i_ext.req <= 1'b0;
        #1;
        while (!(o_ext_ack | o_ext_refused) && n < 4) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        `CHK({o_ext_ack, o_ext_refused}, {exp_ack, !exp_ack})
    endtask

    //****************************************************************
    // Scenarios
    //****************************************************************

    // Commit attempted while the power-up timer still runs
    task automatic t_powerup;
        chk_rd(`DEW_OFF_CTRL, 8'h00, 8'hFF);
        chk_rd(`DEW_OFF_IRQ_MASK, 8'h00, 8'hFF);
        chk_rd(`DEW_OFF_STATUS, 8'h02, 8'h02);
        wr(`DEW_OFF_CTRL, 8'h04);
        unlock();
        wr(`DEW_OFF_CTRL, 8'h06);
        repeat (2) @(posedge i_core_clk);
        `CHK(o_arr.wr, 1'b0)
        chk_rd(`DEW_OFF_CTRL, 8'h04, 8'hFF);
        chk_rd(`DEW_OFF_IRQ_STAT, 8'h02, 8'h03);
        repeat (PWRT) @(posedge i_core_clk);
        chk_rd(`DEW_OFF_STATUS, 8'h00, 8'h02);
    endtask

    // Missing key, wrong key order, arm clear, arm and commit together
    task automatic t_refuse;
        wr(`DEW_OFF_CTRL, 8'h06);
        chk_rd(`DEW_OFF_CTRL, 8'h04, 8'hFF);
        wr(`DEW_OFF_KEY, `DEW_KEY_SECOND);
        wr(`DEW_OFF_KEY, `DEW_KEY_FIRST);
        wr(`DEW_OFF_CTRL, 8'h06);
        chk_rd(`DEW_OFF_CTRL, 8'h04, 8'hFF);
        wr(`DEW_OFF_CTRL, 8'h00);
        unlock();
        wr(`DEW_OFF_CTRL, 8'h02);
        chk_rd(`DEW_OFF_CTRL, 8'h00, 8'hFF);
        unlock();
        wr(`DEW_OFF_CTRL, 8'h06);
        chk_rd(`DEW_OFF_CTRL, 8'h04, 8'hFF);
        `CHK(o_irq, 1'b0)
        chk_rd(`DEW_OFF_IRQ_STAT, 8'h02, 8'h03);
    endtask

    // Full write; registers frozen while busy; done flag raises interrupt
    task automatic t_write;
        int n;
        n = 0;
        wr(`DEW_OFF_ADDR, 8'h3C);
        wr(`DEW_OFF_DATA, 8'hA5);
        wr(`DEW_OFF_IRQ_MASK, 8'h01);
        unlock();
        wr(`DEW_OFF_CTRL, 8'h06);
        while (o_arr.wr !== 1'b1 && n < 4) begin
            @(posedge i_core_clk);
            n++;
        end
        `CHK({o_arr.wr, o_arr.addr, o_arr.wdata}, {1'b1, 8'h3C, 8'hA5})
        wr(`DEW_OFF_ADDR, 8'h77);
        chk_rd(`DEW_OFF_ADDR, 8'h3C, 8'hFF);
        chk_rd(`DEW_OFF_CTRL, 8'h06, 8'hFF);
        wait_idle();
        chk_rd(`DEW_OFF_CTRL, 8'h04, 8'hFF);
        `CHK(o_irq, 1'b1)
        chk_rd(`DEW_OFF_IRQ_STAT, 8'h01, 8'h03);
        chk_rd(`DEW_OFF_IRQ_STAT, 8'h00, 8'h03);
        `CHK(o_irq, 1'b0)
        wr(`DEW_OFF_CTRL, 8'h00);
    endtask

    // Reserved bit, read start with and without space selects, under protect
    task automatic t_read;
        i_code_prot <= 1'b1;
        i_arr_rdata <= 8'hC3;
        wr(`DEW_OFF_CTRL, 8'h30);
        chk_rd(`DEW_OFF_CTRL, 8'h10, 8'hFF);
        wr(`DEW_OFF_CTRL, 8'h80);
        wr(`DEW_OFF_CTRL, 8'h81);
        chk_rd(`DEW_OFF_DATA, 8'hA5, 8'hFF);
        wr(`DEW_OFF_CTRL, 8'h00);
        wr(`DEW_OFF_CTRL, 8'h01);
        repeat (2) @(posedge i_core_clk);
        `CHK(o_arr.rd, 1'b1)
        chk_rd(`DEW_OFF_CTRL, 8'h00, 8'hFF);
        chk_rd(`DEW_OFF_DATA, 8'hC3, 8'hFF);
        apb(1'b0, 12'h01C, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
    endtask

    // External port refused under protect, granted without it
    task automatic t_ext;
        i_code_prot <= 1'b1;
        ext(1'b1, 1'b0);
        ext(1'b0, 1'b0);
        i_code_prot <= 1'b0;
        i_arr_rdata <= 8'h4E;
        ext(1'b0, 1'b1);
        `CHK(o_ext_rdata, 8'h4E)
    endtask

    // Refresh pass from address 0 until it wraps, reading back each byte
    task automatic t_refresh;
        logic [7:0] a;
        a = 8'h00;
        wr(`DEW_OFF_ADDR, 8'h00);
        wr(`DEW_OFF_CTRL, 8'h04);
        do begin
            i_arr_rdata <= a ^ 8'h5A;
            wr(`DEW_OFF_CTRL, 8'h05);
            unlock();
            wr(`DEW_OFF_CTRL, 8'h06);
            wait_idle();
            `CHK(o_arr.addr, a)
            wr(`DEW_OFF_CTRL, 8'h05);
            chk_rd(`DEW_OFF_DATA, a ^ 8'h5A, 8'hFF);
            a = a + 8'h01;
            wr(`DEW_OFF_ADDR, a);
        end while (a != 8'h00);
        wr(`DEW_OFF_CTRL, 8'h00);
        chk_rd(`DEW_OFF_CTRL, 8'h00, 8'hFF);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence; reset held six cycles
    initial begin
        i_sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        i_code_prot = 1'b0;
        i_ext = '0;
        i_arr_rdata = 8'h00;
        repeat (6) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        t_powerup();
        t_refuse();
        t_write();
        t_read();
        t_ext();
        t_refresh();
        end_sim();
    end

    // Whole run needs about 12000 cycles; the refresh pass dominates
    initial begin
        #300000;
        n_fail++;
        end_sim();
    end
endmodule
